// >>> lcd_col_pkg.sv
package lcd_col_pkg;
  localparam int NUM_COLS = 50;
  localparam int NUM_PAGES = 4;
  localparam logic [5:0] COL_LAST = 6'h31;
  localparam logic [5:0] START_PAGE_CODE = 6'h3e;
  localparam logic [7:0] CMD_COUNT_UP = 8'h3b;
  localparam logic [7:0] CMD_COUNT_DOWN = 8'h3a;
  localparam logic [7:0] CMD_DISP_ON = 8'h39;
  localparam logic [7:0] CMD_DISP_OFF = 8'h38;
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_ON_BIT = 5;
  localparam int STAT_UP_BIT = 4;
  localparam logic [7:0] DOUT_RESET = 8'h00;
  localparam logic [4:0] ROW_RESET = 5'h00;
  localparam int BUSY_PHASES = 1;
endpackage : lcd_col_pkg

// >>> lcd_column_driver_core.sv
`timescale 1ns/100ps
// What this block does
// - Latch addressed RAM row on shift clock rise
// - Line sync loads 5-bit row counter
// - Reset: display off, increment mode
// - Narrow bus: high nibble then low nibble
// - Bytes latched, select line picks instruction/data
// - Data read returns previously fetched byte
// - Each data access steps column counter
// - Up wraps 49 to 0; down decrements
// - Row counter: page high, row low
// - Row counter increments on shift clock fall
// - Start page copied on line sync
// - Display off zeroes column data from the next shift clock rise
// - Busy during instructions; ignore others while busy
// - Busy lasts one to two phase periods
// - Address instruction loads page and column
// - Count mode instruction codes
// - Start page instruction code
// - Display on/off codes keep RAM
// - Data select high: RAM read/write
// - Nibble mode busy after second strobe
// - Column level from pixel and polarity
// - Column order select maps outputs
// - Chip selects gate read and write
module lcd_column_driver_core #(
  parameter int NUM_COLS = lcd_col_pkg::NUM_COLS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic phase_tick,
  input wire logic shift_clock,
  input wire logic frame_polarity,
  input wire logic line_sync,
  input wire logic bus_width_select,
  input wire logic column_order_select,
  input wire logic [2:0] chip_selects,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic data_select,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe,
  output logic busy,
  output logic [NUM_COLS-1:0] column_data,
  output logic [2*NUM_COLS-1:0] column_outputs
);

  // ************************************************************
  // Reset synchroniser
  // ************************************************************
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [1:0] page;
    logic [5:0] col;
    logic up;
    logic disp_on;
    logic [1:0] start_page;
    logic [4:0] row;
    logic [7:0] dout;
    logic [7:0] in_reg;
    logic nib_half;
    logic [3:0] nib_hi;
    logic busy;
    logic [1:0] busy_ph;
    logic sc_q;
    logic ls_q;
    logic [NUM_COLS-1:0] latch;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [7:0] ram [lcd_col_pkg::NUM_PAGES*NUM_COLS];

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic cs_rw;
  logic cs_wr;
  logic wr_byte;
  logic [7:0] wr_val;
  logic rd_data;
  logic rd_stat;
  logic [5:0] col_next;
  logic [5:0] phys_col [NUM_COLS];
  logic [7:0] ram_rd;

  assign cs_rw = chip_selects[1] & chip_selects[2];
  assign cs_wr = chip_selects[0] | cs_rw;
  assign wr_byte = wr_strobe & cs_wr & (bus_width_select | s_q.nib_half);
  assign wr_val = bus_width_select ? db_in : {s_q.nib_hi, db_in[7:4]};
  assign rd_data = rd_strobe & cs_rw & data_select;
  assign rd_stat = rd_strobe & cs_rw & !data_select;
  assign col_next = s_q.up ? ((s_q.col == lcd_col_pkg::COL_LAST) ? 6'h00 : s_q.col + 6'h01)
                           : s_q.col - 6'h01;
  assign ram_rd = ram[s_q.page * NUM_COLS + s_q.col];

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.sc_q = shift_clock;
    s_d.ls_q = line_sync;
    if (shift_clock & !s_q.sc_q) begin
      s_d.latch = '0;
      for (int i = 0; i < NUM_COLS; i++) begin
        s_d.latch[i] = s_q.disp_on & ram[s_q.row[4:3] * NUM_COLS + phys_col[i]][s_q.row[2:0]];
      end
    end
    if (!shift_clock & s_q.sc_q) begin
      s_d.row = s_q.row + 5'h01;
    end
    if (line_sync & !s_q.ls_q) begin
      s_d.row = {s_q.start_page, 3'h0};
    end
    if (s_q.busy & phase_tick) begin
      s_d.busy_ph = s_q.busy_ph + 2'h1;
      if (s_q.busy_ph == 2'(lcd_col_pkg::BUSY_PHASES)) begin
        s_d.busy = 1'b0;
        s_d.busy_ph = 2'h0;
      end
    end
    if (wr_strobe & cs_wr & !bus_width_select) begin
      s_d.nib_half = !s_q.nib_half;
      if (!s_q.nib_half) begin
        s_d.nib_hi = db_in[7:4];
      end
    end
    if (wr_byte & !s_q.busy) begin
      s_d.in_reg = wr_val;
      s_d.busy = 1'b1;
      s_d.busy_ph = 2'h0;
      if (data_select) begin
        s_d.col = col_next;
      end else if (wr_val[5:0] == lcd_col_pkg::START_PAGE_CODE) begin
        s_d.start_page = wr_val[7:6];
      end else if (wr_val == lcd_col_pkg::CMD_COUNT_UP) begin
        s_d.up = 1'b1;
      end else if (wr_val == lcd_col_pkg::CMD_COUNT_DOWN) begin
        s_d.up = 1'b0;
      end else if (wr_val == lcd_col_pkg::CMD_DISP_ON) begin
        s_d.disp_on = 1'b1;
      end else if (wr_val == lcd_col_pkg::CMD_DISP_OFF) begin
        s_d.disp_on = 1'b0;
      end else if (wr_val[5:0] <= lcd_col_pkg::COL_LAST) begin
        s_d.page = wr_val[7:6];
        s_d.col = wr_val[5:0];
      end
    end
    if (rd_data & !s_q.busy) begin
      s_d.dout = ram_rd;
      s_d.col = col_next;
      s_d.busy = 1'b1;
      s_d.busy_ph = 2'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q <= '0;
      s_q.up <= 1'b1;
      s_q.disp_on <= 1'b0;
      s_q.row <= lcd_col_pkg::ROW_RESET;
      s_q.dout <= lcd_col_pkg::DOUT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_sync_n & wr_byte & !s_q.busy & data_select) begin
      ram[s_q.page * NUM_COLS + s_q.col] <= wr_val;
    end
  end

  // ************************************************************
  // Column mapping and drive
  // ************************************************************
  for (genvar i = 0; i < NUM_COLS; i++) begin : g_col
    localparam int HALF = NUM_COLS / 2;
    localparam int ODD_MAP = (i < HALF) ? 2 * i : 2 * (NUM_COLS - 1 - i) + 1;
    assign phys_col[i] = column_order_select ? 6'(i) : 6'(ODD_MAP);
    assign column_data[i] = s_q.latch[i];
    assign column_outputs[2*i+1:2*i] = {s_q.latch[i], s_q.latch[i] ^ frame_polarity};
  end

  // ************************************************************
  // Read bus
  // ************************************************************
  always_comb begin
    db_out = s_q.dout;
    if (rd_stat) begin
      db_out = 8'h00;
      db_out[lcd_col_pkg::STAT_BUSY_BIT] = s_q.busy;
      db_out[lcd_col_pkg::STAT_ON_BIT] = s_q.disp_on;
      db_out[lcd_col_pkg::STAT_UP_BIT] = s_q.up;
    end
  end
  assign db_oe = rd_strobe & cs_rw;
  assign busy = s_q.busy;

  // ************************************************************
  // Checks
  // ************************************************************
  chk_reset_mode: assert property (@(posedge clk_sys)
    $rose(rst_sync_n) |-> s_q.up && !s_q.disp_on)
    else $error("Reset state wrong");

  chk_busy_set: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_byte && !s_q.busy) |=> busy)
    else $error("Busy not set");

  chk_busy_ignore: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_byte && s_q.busy && !data_select) |=> $stable(s_q.disp_on) && $stable(s_q.page))
    else $error("Instruction taken while busy");

  chk_wrap_up: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (rd_data && !busy && s_q.up && s_q.col == 6'h31) |=> s_q.col == 6'h00)
    else $error("Column wrap wrong");

  chk_step_down: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (rd_data && !busy && !s_q.up) |=> s_q.col == $past(s_q.col) - 6'h01)
    else $error("Column step wrong");

  chk_step_up: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (rd_data && !busy && s_q.up && s_q.col != 6'h31) |=> s_q.col == $past(s_q.col) + 6'h01)
    else $error("Column step up wrong");

  chk_row_inc: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    ($fell(shift_clock) && !$rose(line_sync)) |=> s_q.row == $past(s_q.row) + 5'h01)
    else $error("Row not stepped");

  chk_sync_load: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    $rose(line_sync) |=> s_q.row == {$past(s_q.start_page), 3'h0})
    else $error("Sync load wrong");

  chk_off_blank: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    ($rose(shift_clock) && !s_q.disp_on) |=> column_data == '0)
    else $error("Display off not blank");

  chk_busy_len: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    $rose(busy) |-> busy [*2])
    else $error("Busy too short");

  chk_first_nibble: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_strobe && cs_wr && !bus_width_select && !s_q.nib_half && !s_q.busy) |=> !busy)
    else $error("First nibble set busy");

  chk_read_fetch: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (rd_data && !s_q.busy) |=> s_q.dout == $past(ram_rd))
    else $error("Read fetch wrong");

  chk_status_byte: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    rd_stat |-> db_out[7] == s_q.busy && db_out[5] == s_q.disp_on)
    else $error("Status byte wrong");

  chk_oe_gate: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    db_oe |-> chip_selects[1] && chip_selects[2])
    else $error("Read enabled without selects");

  chk_write_gate: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_strobe && !chip_selects[0] && !(chip_selects[1] && chip_selects[2]) && !s_q.busy)
    |=> !busy)
    else $error("Write taken while disabled");

  chk_disp_on: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_byte && !s_q.busy && !data_select && wr_val == lcd_col_pkg::CMD_DISP_ON) |=> s_q.disp_on)
    else $error("Display on not taken");

  chk_disp_off: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_byte && !s_q.busy && !data_select && wr_val == lcd_col_pkg::CMD_DISP_OFF) |=> !s_q.disp_on)
    else $error("Display off not taken");

  chk_mode_up: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_byte && !s_q.busy && !data_select && wr_val == lcd_col_pkg::CMD_COUNT_UP) |=> s_q.up)
    else $error("Up mode not taken");

  chk_mode_down: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_byte && !s_q.busy && !data_select && wr_val == lcd_col_pkg::CMD_COUNT_DOWN) |=> !s_q.up)
    else $error("Down mode not taken");

  chk_start_page: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_byte && !s_q.busy && !data_select && wr_val[5:0] == lcd_col_pkg::START_PAGE_CODE)
    |=> s_q.start_page == $past(wr_val[7:6]))
    else $error("Start page not taken");

  chk_addr_load: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_byte && !s_q.busy && !data_select && !rd_strobe && wr_val[5:0] <= lcd_col_pkg::COL_LAST)
    |=> s_q.col == $past(wr_val[5:0]) && s_q.page == $past(wr_val[7:6]))
    else $error("Address not loaded");

  chk_col_level: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    column_outputs[1] == column_data[0] && column_outputs[0] == (column_data[0] ^ frame_polarity))
    else $error("Column level wrong");

endmodule : lcd_column_driver_core

// >>> mpu_model.sv
`timescale 1ns/100ps
module mpu_model (
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  output logic [2:0] chip_selects,
  output logic wr_strobe,
  output logic rd_strobe,
  output logic data_select,
  output logic [7:0] db_in
);
  logic [7:0] rd_q;
  logic oe_q;
  initial begin
    chip_selects = 3'h7;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    data_select = 1'b0;
    db_in = 8'h00;
  end
  // ****************
  // Bus cycles
  // ****************
  task automatic cyc(input logic rd, input logic ds, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    rd_strobe = rd;
    wr_strobe = !rd;
    data_select = ds;
    db_in = d;
    @(posedge clk_sys);
    rd_q = db_out;
    oe_q = db_oe;
    #1;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    db_in = ~d;
  endtask : cyc
  task automatic set_cs(input logic [2:0] c);
    chip_selects = c;
  endtask : set_cs
  task automatic nib(input logic ds, input logic [7:0] d);
    cyc(1'b0, ds, {d[7:4], 4'h0});
    cyc(1'b0, ds, {d[3:0], 4'h0});
  endtask : nib
  task automatic poll(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      cyc(1'b1, 1'b0, 8'h00);
      ok = (rd_q[lcd_col_pkg::STAT_BUSY_BIT] === 1'b0);
    end
  endtask : poll
endmodule : mpu_model

// >>> lcd_column_driver_core_tb_top.sv
`timescale 1ns/100ps
module lcd_column_driver_core_tb_top;
  logic clk_sys, rst_n, shift_clock, line_sync, bus_width_select;
  logic frame_polarity, column_order_select;
  logic phase_tick = 1'b0;
  int tick_cnt = 0;
  logic wr_strobe, rd_strobe, data_select, db_oe, busy;
  logic [2:0] chip_selects;
  logic [7:0] db_in, db_out, v;
  logic [49:0] column_data;
  logic [99:0] column_outputs;
  int fails, n_checks;
  lcd_column_driver_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .phase_tick(phase_tick),
    .shift_clock(shift_clock), .frame_polarity(frame_polarity), .line_sync(line_sync),
    .bus_width_select(bus_width_select), .column_order_select(column_order_select),
    .chip_selects(chip_selects), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .data_select(data_select), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
    .busy(busy), .column_data(column_data), .column_outputs(column_outputs));
  mpu_model mpu_u (.clk_sys(clk_sys), .busy(busy), .db_out(db_out), .db_oe(db_oe),
    .chip_selects(chip_selects), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .data_select(data_select), .db_in(db_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    tick_cnt <= (tick_cnt + 1) % 8;
    phase_tick <= (tick_cnt == 7);
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic idle();
    bit ok;
    mpu_u.poll(ok);
    if (!ok) begin
      fails++;
      report_and_stop();
    end
  endtask : idle
  task automatic ins(input logic ds, input logic [7:0] d);
    idle();
    if (bus_width_select) mpu_u.cyc(1'b0, ds, d);
    else mpu_u.nib(ds, d);
  endtask : ins
  task automatic rd();
    idle();
    mpu_u.cyc(1'b1, 1'b1, 8'h00);
    v = mpu_u.rd_q;
  endtask : rd
  task automatic frame();
    line_sync = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    line_sync = 1'b0;
    shift_clock = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    shift_clock = 1'b0;
  endtask : frame
  // ****************
  // Scenarios
  // ****************
  task automatic t_data();
    ins(1'b0, 8'h71);
    ins(1'b1, 8'ha5);
    @(posedge clk_sys);
    #1;
    chk("busy", 8'h01, {7'h00, busy});
    mpu_u.cyc(1'b0, 1'b1, 8'hff);
    ins(1'b1, 8'h3c);
    ins(1'b0, 8'h71);
    rd();
    rd();
    chk("rd col49", 8'ha5, v);
    rd();
    chk("rd col0", 8'h3c, v);
  endtask : t_data
  task automatic t_down();
    ins(1'b0, lcd_col_pkg::CMD_COUNT_DOWN);
    ins(1'b0, 8'h41);
    ins(1'b1, 8'h5a);
    ins(1'b0, 8'h41);
    rd();
    rd();
    chk("rd down", 8'h5a, v);
    rd();
    chk("rd down next", 8'h3c, v);
    ins(1'b0, lcd_col_pkg::CMD_COUNT_UP);
  endtask : t_down
  task automatic t_nibble();
    bus_width_select = 1'b0;
    ins(1'b0, 8'h00);
    ins(1'b1, 8'hc3);
    bus_width_select = 1'b1;
    chk("busy nib", 8'h01, {7'h00, busy});
    ins(1'b0, 8'h00);
    rd();
    rd();
    chk("rd nib", 8'hc3, v);
  endtask : t_nibble
  task automatic t_display();
    ins(1'b0, 8'h3e);
    frame();
    chk("off cols", 8'h00, {7'h00, |column_data});
    ins(1'b0, lcd_col_pkg::CMD_DISP_ON);
    frame();
    chk("on cols", 8'h01, {7'h00, |column_data});
    chk("col lvl fp0", 8'h03, {6'h00, column_outputs[1:0]});
    frame_polarity = 1'b1;
    @(posedge clk_sys);
    #1;
    chk("col lvl fp1", 8'h02, {6'h00, column_outputs[1:0]});
    ins(1'b0, 8'h02);
    ins(1'b1, 8'h01);
    column_order_select = 1'b0;
    frame();
    chk("odd even map", 8'h01, {7'h00, column_data[1]});
  endtask : t_display
  task automatic t_select();
    idle();
    mpu_u.set_cs(3'h1);
    mpu_u.cyc(1'b1, 1'b0, 8'h00);
    chk("oe wr only", 8'h00, {7'h00, mpu_u.oe_q});
    mpu_u.cyc(1'b0, 1'b0, lcd_col_pkg::CMD_DISP_OFF);
    chk("busy wr only", 8'h01, {7'h00, busy});
    mpu_u.set_cs(3'h7);
  endtask : t_select
  initial begin
    {rst_n, shift_clock, line_sync, frame_polarity} = '0;
    column_order_select = 1'b1;
    bus_width_select = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    mpu_u.cyc(1'b1, 1'b0, 8'h00);
    chk("status", 8'h01, {5'h00, mpu_u.rd_q[7], mpu_u.rd_q[5:4]});
    chk("oe rw", 8'h01, {7'h00, mpu_u.oe_q});
    t_data();
    t_down();
    t_nibble();
    t_select();
    t_display();
    report_and_stop();
  end
endmodule : lcd_column_driver_core_tb_top
